// ===== hw/bmcr_pkg.sv
package bmcr_pkg;

   // Register bus geometry
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 32;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_SWAP_DATA = 6'h0c;
   localparam logic [ADDR_W-1:0] OFF_SWAP_CMP  = 6'h10;
   localparam logic [ADDR_W-1:0] OFF_SWAP_CTRL = 6'h14;
   localparam logic [ADDR_W-1:0] OFF_ROM_HDR   = 6'h18;
   localparam logic [ADDR_W-1:0] OFF_BUS_IDENT = 6'h1c;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT  = 6'h24;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 6'h28;
   localparam logic [ADDR_W-1:0] OFF_SWAP_OLD  = 6'h2c;

   // Swap control fields
   localparam int unsigned CTRL_DONE_BIT = 31;
   localparam int unsigned CTRL_SEL_LSB  = 0;
   localparam int unsigned CTRL_SEL_W    = 2;

   // ROM header fields
   localparam int unsigned HDR_INFO_LSB = 24;
   localparam int unsigned HDR_CRCL_LSB = 16;
   localparam int unsigned HDR_LEN_W    = 8;

   // Values after reset and constants
   localparam logic                  CTRL_DONE_RST = 1'b1;
   localparam logic [CTRL_SEL_W-1:0] CTRL_SEL_RST  = 2'h0;
   localparam logic [DATA_W-1:0]     ROM_HDR_RST   = 32'h0000_0000;
   localparam logic [DATA_W-1:0]     SWAP_REG_RST  = 32'h0000_0000;
   localparam logic [DATA_W-1:0]     BUS_IDENT_VAL = 32'h3133_3934;
   localparam logic [47:0]           ROM_BASE_ADDR = 48'hffff_f000_0400;
   localparam logic [DATA_W-1:0]     RES_RST_VAL   = 32'h0000_0000;

   // Interrupt layout
   localparam int unsigned        IRQ_W        = 1;
   localparam int unsigned        IRQ_SWAP_BIT = 0;
   localparam logic [IRQ_W-1:0]   IRQ_RST      = 1'h0;

   // Swap target resources
   typedef enum logic [CTRL_SEL_W-1:0] {
      TGT_BUS_MANAGER_ID  = 2'h0,
      TGT_BANDWIDTH_AVAIL = 2'h1,
      TGT_CHANNELS_HI     = 2'h2,
      TGT_CHANNELS_LO     = 2'h3
   } bmcr_target_t;

   // Swap engine states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_DONE = 3'b100
   } bmcr_state_t;

endpackage

// ===== hw/bmcr_swap_engine.sv
`timescale 1ns/100ps
`default_nettype none
module bmcr_swap_engine
   import bmcr_pkg::*;
(
   // Clock and reset
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_reset_n,
   // Request
   input  wire logic                  i_start,
   input  wire logic [CTRL_SEL_W-1:0] i_sel,
   input  wire logic [DATA_W-1:0]     i_compare,
   input  wire logic [DATA_W-1:0]     i_data,
   // Result
   output logic                       o_busy,
   output logic                       o_done,
   output logic [DATA_W-1:0]          o_old_value,
   output logic [3:0][DATA_W-1:0]     o_resources
);

   bmcr_state_t               state_q;
   logic [CTRL_SEL_W-1:0]     sel_q;
   logic [DATA_W-1:0]         cmp_q;
   logic [DATA_W-1:0]         data_q;

   // Sequencer: latch, swap, report
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         state_q <= ST_IDLE;
      else
      begin
         unique case (state_q)
            ST_IDLE: if (i_start) state_q <= ST_EXEC;
            ST_EXEC: state_q <= ST_DONE;
            ST_DONE: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Operands frozen at start
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         sel_q  <= CTRL_SEL_RST;
         cmp_q  <= SWAP_REG_RST;
         data_q <= SWAP_REG_RST;
      end
      else if (state_q == ST_IDLE && i_start)
      begin
         sel_q  <= i_sel;
         cmp_q  <= i_compare;
         data_q <= i_data;
      end
   end

   // Compare-swap on the selected resource
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         o_resources <= {4{RES_RST_VAL}};
         o_old_value <= SWAP_REG_RST;
      end
      else if (state_q == ST_EXEC)
      begin
         o_old_value <= o_resources[sel_q];
         if (o_resources[sel_q] == cmp_q)
            o_resources[sel_q] <= data_q;
      end
   end

   assign o_busy = (state_q != ST_IDLE);
   assign o_done = (state_q == ST_DONE);

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   a_swap_match: assert property ((state_q == ST_EXEC) && (o_resources[sel_q] == cmp_q)
      |=> o_resources[$past(sel_q)] == $past(data_q))
      else $error("matching swap did not store data");
   a_swap_miss: assert property ((state_q == ST_EXEC) && (o_resources[sel_q] != cmp_q)
      |=> $stable(o_resources))
      else $error("failed compare changed a resource");

endmodule
`default_nettype wire

// ===== hw/bmcr_regs.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Finished swap sets the completion flag.
// - A control write clears the completion flag, except in the cycle a swap finishes.
// - Control reserved middle bits read zero.
// - Two low bits pick swap resource.
// - Header exported as first ROM quadlet.
// - Header length bytes reset to zero.
// - Bus ident reads constant, read-only.
// - Bus ident exported as info block quadlet.
// - Data register holds value to store.
// - Compare register holds value to compare.
module bmcr_regs
   import bmcr_pkg::*;
(
   // Clock and reset
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_reset_n,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0]     i_avs_address,
   input  wire logic                  i_avs_read,
   input  wire logic                  i_avs_write,
   input  wire logic [DATA_W-1:0]     i_avs_writedata,
   output logic [DATA_W-1:0]          o_avs_readdata,
   output logic                       o_avs_waitrequest,
   // Configuration ROM view
   output logic [47:0]                o_rom_base_addr,
   output logic [DATA_W-1:0]          o_rom_quadlet0,
   output logic [DATA_W-1:0]          o_bus_info_quadlet0,
   // Bus-management resources
   output logic [3:0][DATA_W-1:0]     o_resources,
   // Interrupt
   output logic                       o_irq
);

   logic                    ack_q;
   logic                    rd_cap;
   logic                    wr_fire;
   logic                    done_q;
   logic [CTRL_SEL_W-1:0]   sel_q;
   logic [DATA_W-1:0]       swap_data_q;
   logic [DATA_W-1:0]       swap_cmp_q;
   logic [DATA_W-1:0]       hdr_q;
   logic [DATA_W-1:0]       bus_ident_q;
   logic [IRQ_W-1:0]        irq_stat_q;
   logic [IRQ_W-1:0]        irq_mask_q;
   logic [IRQ_W-1:0]        irq_event;
   logic                    eng_start;
   logic                    eng_busy;
   logic                    eng_done;
   logic [DATA_W-1:0]       eng_old;

   // Address match shared by read and write paths
   function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                input logic [ADDR_W-1:0] off);
      hit = (addr == off);
   endfunction

   // Read value of each register, zero when unmapped
   function automatic logic [DATA_W-1:0] rd_value(input logic [ADDR_W-1:0] addr);
      logic [DATA_W-1:0] v;
      v = '0;
      if (hit(addr, OFF_SWAP_DATA))
         v = swap_data_q;
      else if (hit(addr, OFF_SWAP_CMP))
         v = swap_cmp_q;
      else if (hit(addr, OFF_SWAP_CTRL))
      begin
         v[CTRL_DONE_BIT] = done_q;
         v[CTRL_SEL_LSB +: CTRL_SEL_W] = sel_q;
      end
      else if (hit(addr, OFF_ROM_HDR))
         v = hdr_q;
      else if (hit(addr, OFF_BUS_IDENT))
         v = bus_ident_q;
      else if (hit(addr, OFF_IRQ_STAT))
         v[IRQ_W-1:0] = irq_stat_q;
      else if (hit(addr, OFF_IRQ_MASK))
         v[IRQ_W-1:0] = irq_mask_q;
      else if (hit(addr, OFF_SWAP_OLD))
         v = eng_old;
      rd_value = v;
   endfunction

   // One wait cycle per access, then completion
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         ack_q <= 1'b0;
      else
         ack_q <= (i_avs_read || i_avs_write) && !ack_q;
   end

   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
   assign rd_cap  = i_avs_read && !ack_q;
   assign wr_fire = i_avs_write && ack_q;

   // Read data captured in the wait cycle
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         o_avs_readdata <= '0;
      else if (rd_cap)
         o_avs_readdata <= rd_value(i_avs_address);
   end

   // Completion flag: set beats clear
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         done_q <= CTRL_DONE_RST;
      else if (eng_done)
         done_q <= 1'b1;
      else if (wr_fire && hit(i_avs_address, OFF_SWAP_CTRL))
         done_q <= 1'b0;
   end

   // Resource select, only the low field is stored
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         sel_q <= CTRL_SEL_RST;
      else if (wr_fire && hit(i_avs_address, OFF_SWAP_CTRL))
         sel_q <= i_avs_writedata[CTRL_SEL_LSB +: CTRL_SEL_W];
   end

   // Swap operands
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         swap_data_q <= SWAP_REG_RST;
         swap_cmp_q  <= SWAP_REG_RST;
      end
      else if (wr_fire)
      begin
         if (hit(i_avs_address, OFF_SWAP_DATA))
            swap_data_q <= i_avs_writedata;
         if (hit(i_avs_address, OFF_SWAP_CMP))
            swap_cmp_q <= i_avs_writedata;
      end
   end

   // ROM header quadlet
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         hdr_q <= ROM_HDR_RST;
      else if (wr_fire && hit(i_avs_address, OFF_ROM_HDR))
         hdr_q <= i_avs_writedata;
   end

   // Constant identification word held in a flop
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         bus_ident_q <= BUS_IDENT_VAL;
      else
         bus_ident_q <= BUS_IDENT_VAL;
   end

   // ROM-facing copies
   assign o_rom_base_addr     = ROM_BASE_ADDR;
   assign o_rom_quadlet0      = hdr_q;
   assign o_bus_info_quadlet0 = bus_ident_q;

   // Start pulse: a control write kicks the engine
   assign eng_start = wr_fire && hit(i_avs_address, OFF_SWAP_CTRL);

   bmcr_swap_engine u_engine (
      .i_ref_clk   (i_ref_clk),
      .i_reset_n   (i_reset_n),
      .i_start     (eng_start),
      .i_sel       (i_avs_writedata[CTRL_SEL_LSB +: CTRL_SEL_W]),
      .i_compare   (swap_cmp_q),
      .i_data      (swap_data_q),
      .o_busy      (eng_busy),
      .o_done      (eng_done),
      .o_old_value (eng_old),
      .o_resources (o_resources)
   );

   // Interrupt events
   always_comb
   begin
      irq_event = '0;
      irq_event[IRQ_SWAP_BIT] = eng_done;
   end

   // Sticky status, write one to clear, set wins
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         irq_stat_q <= IRQ_RST;
      else if (wr_fire && hit(i_avs_address, OFF_IRQ_STAT))
         irq_stat_q <= (irq_stat_q & ~i_avs_writedata[IRQ_W-1:0]) | irq_event;
      else
         irq_stat_q <= irq_stat_q | irq_event;
   end

   // Interrupt mask
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         irq_mask_q <= IRQ_RST;
      else if (wr_fire && hit(i_avs_address, OFF_IRQ_MASK))
         irq_mask_q <= i_avs_writedata[IRQ_W-1:0];
   end

   assign o_irq = |(irq_stat_q & irq_mask_q);

   // Checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   sequence s_ctrl_write;
      wr_fire && hit(i_avs_address, OFF_SWAP_CTRL);
   endsequence

   sequence s_swap_report;
      ##[1:3] eng_done ##1 done_q;
   endsequence

   sequence s_read_of(logic [ADDR_W-1:0] off);
      rd_cap && hit(i_avs_address, off);
   endsequence

   a_done_set: assert property (eng_done |=> done_q)
      else $error("completion flag not set after swap");
   a_done_clear: assert property (s_ctrl_write and !eng_done |=> !done_q)
      else $error("control write did not clear completion flag");
   a_ctrl_rsvd: assert property (s_read_of(OFF_SWAP_CTRL) |=> o_avs_readdata[30:2] == '0)
      else $error("reserved control bits read nonzero");
   a_sel_store: assert property (s_ctrl_write
      |=> sel_q == $past(i_avs_writedata[1:0]))
      else $error("resource select not stored");
   a_rom_export: assert property (wr_fire && hit(i_avs_address, OFF_ROM_HDR)
      |=> o_rom_quadlet0 == $past(i_avs_writedata))
      else $error("ROM quadlet does not follow header write");
   a_hdr_reset: assert property ($past(!i_reset_n) |-> hdr_q[31:16] == 16'h0000)
      else $error("header lengths not zero after reset");
   a_ident_read: assert property (s_read_of(OFF_BUS_IDENT)
      |=> o_avs_readdata == 32'h3133_3934)
      else $error("bus ident read wrong value");
   a_ident_export: assert property (o_bus_info_quadlet0 == 32'h3133_3934)
      else $error("bus info quadlet wrong");
   a_data_store: assert property (wr_fire && hit(i_avs_address, OFF_SWAP_DATA)
      |=> swap_data_q == $past(i_avs_writedata))
      else $error("swap data not stored");
   a_cmp_store: assert property (wr_fire && hit(i_avs_address, OFF_SWAP_CMP)
      |=> swap_cmp_q == $past(i_avs_writedata))
      else $error("swap compare not stored");
   a_swap_runs: assert property (s_ctrl_write and !eng_busy |-> s_swap_report)
      else $error("control write did not complete a swap");
   a_wait_once: assert property ((i_avs_read || i_avs_write) && !ack_q
      |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
      else $error("waitrequest not released after one cycle");
   a_irq_level: assert property (irq_stat_q[IRQ_SWAP_BIT] && irq_mask_q[IRQ_SWAP_BIT]
      |-> o_irq)
      else $error("unmasked status without interrupt");

   // Completion flag against clears and reads
   a_done_wins: assert property (s_ctrl_write and eng_done |=> done_q)
      else $error("clear beat completion flag set");
   a_done_hold: assert property (!eng_done && !(wr_fire && hit(i_avs_address, OFF_SWAP_CTRL))
      |=> $stable(done_q))
      else $error("completion flag changed without cause");
   a_done_read: assert property (s_read_of(OFF_SWAP_CTRL)
      |=> o_avs_readdata[31] == $past(done_q))
      else $error("completion flag read wrong");

   // Resource select storage and read-back
   a_sel_hold: assert property (!(wr_fire && hit(i_avs_address, OFF_SWAP_CTRL))
      |=> $stable(sel_q))
      else $error("resource select changed without write");
   a_sel_read: assert property (s_read_of(OFF_SWAP_CTRL)
      |=> o_avs_readdata[1:0] == $past(sel_q))
      else $error("resource select read wrong");

   // Header storage and read-back
   a_hdr_hold: assert property (!(wr_fire && hit(i_avs_address, OFF_ROM_HDR))
      |=> $stable(hdr_q))
      else $error("header changed without write");
   a_hdr_read: assert property (s_read_of(OFF_ROM_HDR)
      |=> o_avs_readdata == $past(hdr_q))
      else $error("header read wrong");

   // Operands keep their value between writes
   a_data_hold: assert property (!(wr_fire && hit(i_avs_address, OFF_SWAP_DATA))
      |=> $stable(swap_data_q))
      else $error("swap data changed without write");
   a_cmp_hold: assert property (!(wr_fire && hit(i_avs_address, OFF_SWAP_CMP))
      |=> $stable(swap_cmp_q))
      else $error("swap compare changed without write");

   // Engine accepts one swap at a time
   a_busy_refuse: assert property (eng_start && eng_done |=> !eng_busy)
      else $error("control write restarted a busy engine");
   a_one_done: assert property (eng_done |=> !eng_done)
      else $error("completion pulse longer than one cycle");

   // Sticky status: set wins over write one to clear
   a_stat_wins: assert property (eng_done |=> irq_stat_q[IRQ_SWAP_BIT])
      else $error("swap status not set");
   a_stat_clear: assert property (wr_fire && hit(i_avs_address, OFF_IRQ_STAT)
      && i_avs_writedata[IRQ_SWAP_BIT] && !eng_done |=> !irq_stat_q[IRQ_SWAP_BIT])
      else $error("swap status not cleared");
   a_mask_hold: assert property (!(wr_fire && hit(i_avs_address, OFF_IRQ_MASK))
      |=> $stable(irq_mask_q))
      else $error("mask changed without write");

   // Bus handshake and read data
   a_wait_idle: assert property (!i_avs_read && !i_avs_write |-> !o_avs_waitrequest)
      else $error("waitrequest raised without request");
   a_rd_hold: assert property (!rd_cap |=> $stable(o_avs_readdata))
      else $error("read data changed outside capture");
   a_unmapped_rd: assert property (s_read_of(6'h20) |=> o_avs_readdata == '0)
      else $error("unmapped read not zero");

endmodule
`default_nettype wire

// ===== verif/bmcr_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
   import bmcr_pkg::*;
;
   typedef struct packed
   {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wd;
      logic [DATA_W-1:0] exp;
   } bmcr_row_t;

   logic                   ref_clk;
   logic                   reset_n;
   logic [ADDR_W-1:0]      address;
   logic                   rd;
   logic                   wr;
   logic [DATA_W-1:0]      wdata;
   logic [DATA_W-1:0]      rdata;
   logic                   waitreq;
   logic [47:0]            rom_base;
   logic [DATA_W-1:0]      rom_q0;
   logic [DATA_W-1:0]      info_q0;
   logic [3:0][DATA_W-1:0] res;
   logic                   irq;
   logic [DATA_W-1:0]      r;
   int                     error_cnt;
   int                     checks_done;
   bmcr_row_t              rows [5];

   // Device under test
   bmcr_regs uut
   (
      .i_ref_clk           (ref_clk),
      .i_reset_n           (reset_n),
      .i_avs_address       (address),
      .i_avs_read          (rd),
      .i_avs_write         (wr),
      .i_avs_writedata     (wdata),
      .o_avs_readdata      (rdata),
      .o_avs_waitrequest   (waitreq),
      .o_rom_base_addr     (rom_base),
      .o_rom_quadlet0      (rom_q0),
      .o_bus_info_quadlet0 (info_q0),
      .o_resources         (res),
      .o_irq               (irq)
   );

   // 250 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Verdict and end of run
   task automatic close_out();
      $display("Checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Compare seen against expected
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One bus transfer, held until waitrequest is sampled low at a rising edge
   // lead: follow a kept request at once; keep: leave the request raised
   task automatic xfer(input logic we, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
                       input logic lead, input logic keep);
      int   n;
      logic w;
      if (!lead)
         @(posedge ref_clk);
      address <= a;
      wdata <= d;
      wr <= we;
      rd <= !we;
      n = 0;
      w = 1'b1;
      while (w)
      begin
         @(posedge ref_clk);
         w = (waitreq !== 1'b0);
         n++;
         if (w && n > 50)
         begin
            error_cnt++;
            close_out();
         end
      end
      q = rdata;
      if (!keep)
      begin
         wr <= 1'b0;
         rd <= 1'b0;
      end
   endtask

   task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] q;
      xfer(1'b1, a, d, q, 1'b0, 1'b0);
   endtask

   task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
      xfer(1'b0, a, 32'h0, q, 1'b0, 1'b0);
   endtask

   // Load operands, start a swap, poll completion, check the resource
   task automatic do_swap(input logic [1:0] sel, input logic [31:0] cmp,
                          input logic [31:0] dat, input logic [31:0] old,
                          input logic [31:0] exp);
      int n;
      bus_wr(OFF_SWAP_DATA, dat);
      bus_wr(OFF_SWAP_CMP, cmp);
      bus_wr(OFF_SWAP_CTRL, 32'h7fff_fffc | {30'h0, sel});
      bus_rd(OFF_SWAP_CTRL, r);
      chk(r, {30'h0, sel});
      n = 0;
      while (r[31] !== 1'b1)
      begin
         bus_rd(OFF_SWAP_CTRL, r);
         n++;
         if (n > 20)
         begin
            error_cnt++;
            close_out();
         end
      end
      chk(r, 32'h8000_0000 | {30'h0, sel});
      @(negedge ref_clk);
      chk(res[sel], exp);
      bus_rd(OFF_SWAP_OLD, r);
      chk(r, old);
   endtask

   // Reset and check the values it leaves
   task automatic do_reset();
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      bus_rd(OFF_SWAP_CTRL, r);
      chk(r, 32'h8000_0000);
      bus_rd(OFF_ROM_HDR, r);
      chk(r, 32'h0);
      bus_rd(OFF_BUS_IDENT, r);
      chk(r, 32'h3133_3934);
      @(negedge ref_clk);
      chk(rom_base, 48'hffff_f000_0400);
      chk(info_q0, 32'h3133_3934);
      chk({47'h0, irq}, 48'h0);
      chk({16'h0, res[0] | res[1] | res[2] | res[3]}, 48'h0);
   endtask

   // Main sequence
   initial
   begin
      reset_n = 1'b0;
      address = '0;
      rd = 1'b0;
      wr = 1'b0;
      wdata = '0;
      error_cnt = 0;
      checks_done = 0;
      rows[0] = '{OFF_ROM_HDR, 32'h1234_5678, 32'h1234_5678};
      rows[1] = '{OFF_BUS_IDENT, 32'hffff_ffff, 32'h3133_3934};
      rows[2] = '{6'h20, 32'hdead_beef, 32'h0};
      rows[3] = '{OFF_SWAP_DATA, 32'h0f0f_0f0f, 32'h0f0f_0f0f};
      rows[4] = '{OFF_SWAP_CMP, 32'hf0f0_f0f0, 32'hf0f0_f0f0};
      do_reset();
      // Ordinary register cases
      foreach (rows[i])
      begin
         bus_wr(rows[i].addr, rows[i].wd);
         bus_rd(rows[i].addr, r);
         chk(r, rows[i].exp);
      end
      chk(rom_q0, 32'h1234_5678);
      // Successful swap on every resource, interrupt raised and cleared
      bus_wr(OFF_IRQ_MASK, 32'h1);
      for (int s = 0; s < 4; s++)
      begin
         do_swap(s[1:0], 32'h0, 32'ha0 + s, 32'h0, 32'ha0 + s);
         chk({47'h0, irq}, 48'h1);
         bus_wr(OFF_IRQ_STAT, 32'h1);
         @(negedge ref_clk);
         chk({47'h0, irq}, 48'h0);
      end
      // Failed compare leaves the resource alone
      do_swap(2'h0, 32'h55, 32'hbb, 32'ha0, 32'ha0);
      bus_wr(OFF_IRQ_STAT, 32'h1);
      // Masked completion keeps the interrupt low
      bus_wr(OFF_IRQ_MASK, 32'h0);
      do_swap(2'h1, 32'ha1, 32'hcc, 32'ha1, 32'hcc);
      chk({47'h0, irq}, 48'h0);
      bus_rd(OFF_IRQ_STAT, r);
      chk(r, 32'h1);
      bus_wr(OFF_IRQ_MASK, 32'h1);
      @(negedge ref_clk);
      chk({47'h0, irq}, 48'h1);
      bus_wr(OFF_IRQ_STAT, 32'h1);
      @(negedge ref_clk);
      chk({47'h0, irq}, 48'h0);
      // Control write in the completion cycle: set wins, no second swap
      bus_wr(OFF_SWAP_DATA, 32'h77);
      bus_wr(OFF_SWAP_CMP, 32'hcc);
      xfer(1'b1, OFF_SWAP_CTRL, 32'h1, r, 1'b0, 1'b1);
      xfer(1'b1, OFF_SWAP_CTRL, 32'h2, r, 1'b1, 1'b0);
      bus_rd(OFF_SWAP_CTRL, r);
      chk(r, 32'h8000_0002);
      bus_rd(OFF_SWAP_OLD, r);
      chk(r, 32'hcc);
      chk(res[1], 32'h77);
      // Status clear in the completion cycle: set wins
      bus_wr(OFF_IRQ_STAT, 32'h1);
      xfer(1'b1, OFF_SWAP_CTRL, 32'h3, r, 1'b0, 1'b1);
      xfer(1'b1, OFF_IRQ_STAT, 32'h1, r, 1'b1, 1'b0);
      bus_rd(OFF_IRQ_STAT, r);
      chk(r, 32'h1);
      // Reset in mid-run
      do_reset();
      close_out();
   end
endmodule
`default_nettype wire
